// ===== nhc_regs.svh
// Timing counts and field layout for the NAND host controller.
// Assumes a 40 MHz system clock; included by nhc_host only.
`ifndef NHC_REGS_SVH
`define NHC_REGS_SVH
`define NHC_CLK_PERIOD_NS 25
`define NHC_READ_ACCESS_DELAY_NS 20
`define NHC_READ_ACCESS_CYC (((`NHC_READ_ACCESS_DELAY_NS + `NHC_CLK_PERIOD_NS - 1) / `NHC_CLK_PERIOD_NS) + 1)
`define NHC_RDY_WAIT_CYC 3
`define NHC_ADDR_CYCLES 5
`define NHC_COL_BITS 12
`define NHC_ROW_BITS 17
`define NHC_PAGE_BITS 6
`define NHC_PAGE_BYTES 2176
`define NHC_MAIN_BYTES 2048
`define NHC_SPARE_BYTES 128
`define NHC_PAGES_PER_BLOCK 64
`endif

// ===== nhc_pkg.sv
// Types for the NAND host controller.
// Assumes nhc_regs.svh sits in the include path.
package nhc_pkg;
  typedef enum logic [1:0] {
    NHC_OP_CMD,
    NHC_OP_ADDR,
    NHC_OP_WRITE,
    NHC_OP_READ
  } nhc_op_t;
  typedef enum logic [2:0] {
    NHC_IDLE,
    NHC_WR_LOW,
    NHC_WR_HIGH,
    NHC_RD_LOW,
    NHC_RD_HIGH,
    NHC_WAIT_RDY
  } nhc_state_t;
endpackage : nhc_pkg

// ===== nhc_fifo.sv
// Small synchronous FIFO for read data from the flash.
// Assumes one clock; ready and valid handshake on both sides.
`timescale 1ns/1ps
module nhc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_ready_out = (cnt_r != DEPTH[AW:0]);
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rp_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule : nhc_fifo

// ===== nhc_host.sv
// Host controller driving an asynchronous 8-bit NAND flash bus.
// Assumes flash pins are synchronous to clock_in and an external pull-up on ready/busy.
// Operation
// - Command strobe high, byte latched at write rise
// - Address strobe high, byte latched at write rise
// - Bytes sampled only on write strobe rise
// - Device answers only with select low, ready
// - Write guard low blocks program and erase
// - Address is five bytes: column, row fields
`timescale 1ns/1ps
`include "nhc_regs.svh"
module nhc_host #(
  parameter int PULSE_CYC = 1,
  parameter int RD_CYC = `NHC_READ_ACCESS_CYC
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire nhc_pkg::nhc_op_t req_op_in,
  input wire logic [7:0] req_data_in,
  input wire logic req_wait_ready_in,
  input wire logic addr_valid_in,
  input wire logic [`NHC_COL_BITS-1:0] addr_col_in,
  input wire logic [`NHC_ROW_BITS-1:0] addr_row_in,
  input wire logic write_enable_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [7:0] rd_data_out,
  output logic busy_out,
  output logic [`NHC_PAGE_BITS-1:0] page_index_out,
  output logic [`NHC_ROW_BITS-`NHC_PAGE_BITS-1:0] block_index_out,
  output logic chip_sel_n_out,
  output logic cmd_latch_out,
  output logic addr_latch_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic write_guard_n_out,
  input wire logic ready_busy_n_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe_out
);
  import nhc_pkg::*;

  function automatic logic [7:0] addr_byte(input logic [2:0] idx,
      input logic [`NHC_COL_BITS-1:0] col, input logic [`NHC_ROW_BITS-1:0] row);
    unique case (idx)
      3'H0: addr_byte = col[7:0];
      3'H1: addr_byte = {4'H0, col[11:8]};
      3'H2: addr_byte = row[7:0];
      3'H3: addr_byte = row[15:8];
      default: addr_byte = {7'H00, row[16]};
    endcase
  endfunction : addr_byte

  nhc_state_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic cle_r, cle_nxt, ale_r, ale_nxt, oe_r, oe_nxt;
  logic [2:0] aidx_r, aidx_nxt;
  logic aseq_r, aseq_nxt;
  logic wait_r, wait_nxt;
  logic [`NHC_COL_BITS-1:0] col_r, col_nxt;
  logic [`NHC_ROW_BITS-1:0] row_r, row_nxt;
  logic fifo_ready;
  logic push;
  logic cnt_done;

  assign cnt_done = (cnt_r == 8'H00);
  assign req_ready_out = (st_r == NHC_IDLE) && !aseq_r && ready_busy_n_in;
  assign push = (st_r == NHC_RD_HIGH) && cnt_done;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 8'H01;
    dout_nxt = dout_r;
    cle_nxt = cle_r;
    ale_nxt = ale_r;
    oe_nxt = oe_r;
    aidx_nxt = aidx_r;
    aseq_nxt = aseq_r;
    wait_nxt = wait_r;
    col_nxt = col_r;
    row_nxt = row_r;
    unique case (st_r)
      NHC_IDLE: begin
        cle_nxt = 1'b0;
        ale_nxt = 1'b0;
        oe_nxt = 1'b0;
        if (aseq_r) begin
          dout_nxt = addr_byte(aidx_r, col_r, row_r);
          ale_nxt = 1'b1;
          oe_nxt = 1'b1;
          cnt_nxt = 8'(PULSE_CYC - 1);
          st_nxt = NHC_WR_LOW;
        end else if (addr_valid_in && ready_busy_n_in) begin
          col_nxt = addr_col_in;
          row_nxt = addr_row_in;
          aidx_nxt = 3'H0;
          aseq_nxt = 1'b1;
        end else if (req_valid_in && req_ready_out) begin
          wait_nxt = req_wait_ready_in;
          cnt_nxt = 8'(PULSE_CYC - 1);
          unique case (req_op_in)
            NHC_OP_CMD: begin
              cle_nxt = 1'b1;
              dout_nxt = req_data_in;
              oe_nxt = 1'b1;
              st_nxt = NHC_WR_LOW;
            end
            NHC_OP_ADDR, NHC_OP_WRITE: begin
              ale_nxt = (req_op_in == NHC_OP_ADDR);
              dout_nxt = req_data_in;
              oe_nxt = 1'b1;
              st_nxt = NHC_WR_LOW;
            end
            NHC_OP_READ: begin
              cnt_nxt = 8'(RD_CYC - 1);
              st_nxt = NHC_RD_LOW;
            end
          endcase
        end
      end
      NHC_WR_LOW: if (cnt_done) begin
        cnt_nxt = 8'(PULSE_CYC - 1);
        st_nxt = NHC_WR_HIGH;
      end
      NHC_WR_HIGH: if (cnt_done) begin
        oe_nxt = 1'b0;
        cle_nxt = 1'b0;
        ale_nxt = 1'b0;
        if (aseq_r) begin
          aidx_nxt = aidx_r + 3'H1;
          if (aidx_r == 3'(`NHC_ADDR_CYCLES - 1)) begin
            aseq_nxt = 1'b0;
          end
          st_nxt = NHC_IDLE;
        end else begin
          cnt_nxt = 8'(`NHC_RDY_WAIT_CYC - 1);
          st_nxt = wait_r ? NHC_WAIT_RDY : NHC_IDLE;
        end
      end
      NHC_RD_LOW: if (cnt_done) begin
        dout_nxt = io_in;
        cnt_nxt = 8'(PULSE_CYC - 1);
        st_nxt = NHC_RD_HIGH;
      end
      NHC_RD_HIGH: if (cnt_done && fifo_ready) begin
        st_nxt = NHC_IDLE;
      end
      NHC_WAIT_RDY: if (cnt_done && ready_busy_n_in) begin
        wait_nxt = 1'b0;
        st_nxt = NHC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= NHC_IDLE;
      cnt_r <= 8'H00;
      dout_r <= 8'H00;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      oe_r <= 1'b0;
      aidx_r <= 3'H0;
      aseq_r <= 1'b0;
      wait_r <= 1'b0;
      col_r <= '0;
      row_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      dout_r <= dout_nxt;
      cle_r <= cle_nxt;
      ale_r <= ale_nxt;
      oe_r <= oe_nxt;
      aidx_r <= aidx_nxt;
      aseq_r <= aseq_nxt;
      wait_r <= wait_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
    end
  end

  assign chip_sel_n_out = (st_r == NHC_IDLE) && !aseq_r;
  assign cmd_latch_out = cle_r;
  assign addr_latch_out = ale_r;
  assign write_strobe_n_out = (st_r != NHC_WR_LOW);
  assign read_strobe_n_out = (st_r != NHC_RD_LOW);
  assign write_guard_n_out = write_enable_in;
  assign io_out = dout_r;
  assign io_oe_out = oe_r && (st_r == NHC_WR_LOW || st_r == NHC_WR_HIGH);
  assign busy_out = !ready_busy_n_in || (st_r == NHC_WAIT_RDY);
  assign page_index_out = row_r[`NHC_PAGE_BITS-1:0];
  assign block_index_out = row_r[`NHC_ROW_BITS-1:`NHC_PAGE_BITS];

  nhc_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(dout_r),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_data_out)
  );
endmodule : nhc_host

// ===== nhc_host_asserts.sv
// Pin-level checker for the NAND host controller.
// Assumes it is bound onto nhc_host and sees only its ports.
`timescale 1ns/1ps
module nhc_host_asserts (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic write_enable_in,
  input wire logic ready_busy_n_in,
  input wire logic busy_out,
  input wire logic chip_sel_n_out,
  input wire logic cmd_latch_out,
  input wire logic addr_latch_out,
  input wire logic write_strobe_n_out,
  input wire logic read_strobe_n_out,
  input wire logic write_guard_n_out,
  input wire logic io_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  latch_excl_a: assert property (!(cmd_latch_out && addr_latch_out))
    else $error("both latches high");
  latch_sel_a: assert property ((cmd_latch_out || addr_latch_out) |-> !chip_sel_n_out)
    else $error("latch without select");
  wr_drive_a: assert property (!write_strobe_n_out |-> io_oe_out && read_strobe_n_out)
    else $error("write strobe without drive");
  rd_float_a: assert property (!read_strobe_n_out |-> !io_oe_out)
    else $error("host drives during read");
  guard_follow_a: assert property (write_guard_n_out == write_enable_in)
    else $error("guard not following enable");
  wr_pulse_a: assert property ($fell(write_strobe_n_out) |=> write_strobe_n_out)
    else $error("write pulse width");
  rd_pulse_a: assert property ($fell(read_strobe_n_out) |=> !read_strobe_n_out ##1 read_strobe_n_out)
    else $error("read pulse width");
  busy_flag_a: assert property (!ready_busy_n_in |-> busy_out)
    else $error("busy not flagged");
  busy_nowr_a: assert property ($fell(write_strobe_n_out) |-> ready_busy_n_in)
    else $error("write while busy");
endmodule : nhc_host_asserts
bind nhc_host nhc_host_asserts chk (.clock_in, .sys_rst_in, .write_enable_in, .ready_busy_n_in,
  .busy_out, .chip_sel_n_out, .cmd_latch_out, .addr_latch_out, .write_strobe_n_out,
  .read_strobe_n_out, .write_guard_n_out, .io_oe_out);

// ===== nhc_flash_model.sv
// Behavioural flash device facing the host controller.
// Assumes the bench resolves the shared byte lane; ready/busy is driven both high and low here.
`timescale 1ns/1ps
module nhc_flash_model #(
  parameter logic [7:0] BUSY_CMD = 8'h10,
  parameter int BUSY_NS = 510
) (
  input wire logic chip_sel_n_in,
  input wire logic cmd_latch_in,
  input wire logic addr_latch_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_guard_n_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic ready_busy_n_out
);
  logic [7:0] cmd_r, data_r, dout_r;
  logic [7:0] addr_q [0:4];
  logic [11:0] col_r = 12'h000;
  logic busy_r = 1'b0;
  logic drv_r = 1'b0;
  int n_r = 0;
  initial dout_r = 8'h00;
  assign ready_busy_n_out = busy_r ? 1'b0 : 1'b1;
  assign io_out = (drv_r && !chip_sel_n_in && !read_strobe_n_in) ? dout_r : ~dout_r;
  always @(posedge write_strobe_n_in) begin
    if (!chip_sel_n_in && !busy_r) begin
      if (cmd_latch_in) begin
        cmd_r = io_in;
        n_r = 0;
      end else if (addr_latch_in) begin
        addr_q[n_r % 5] = io_in;
        n_r++;
        col_r = {addr_q[1][3:0], addr_q[0]};
      end else data_r = io_in;
      if (cmd_latch_in && io_in == BUSY_CMD && write_guard_n_in) begin
        busy_r = 1'b1;
        #(BUSY_NS) busy_r = 1'b0;
      end
    end
  end
  always @(negedge read_strobe_n_in) begin
    drv_r = 1'b0;
    #20;
    if (!chip_sel_n_in && !busy_r) begin
      dout_r = col_r[7:0];
      drv_r = 1'b1;
      col_r++;
    end
  end
endmodule : nhc_flash_model

// ===== tb_top.sv
// Self-checking bench for the NAND host controller.
// Assumes nhc_flash_model stands on the flash pins.
`timescale 1ns/1ps
module tb_top;
  import nhc_pkg::*;
  logic clock_in = 0, sys_rst_in = 1, req_valid_in = 0, req_wait_ready_in = 0;
  logic addr_valid_in = 0, write_enable_in = 1, rd_ready_in = 0;
  nhc_op_t req_op_in = NHC_OP_CMD;
  logic [7:0] req_data_in = 8'h00;
  logic req_ready_out, rd_valid_out, busy_out, cs_n, cle, ale, we_n, re_n, wp_n, rb_n, oe;
  logic [7:0] rd_data_out, h_io, f_io, bus;
  logic [5:0] page;
  logic [10:0] blk;
  int err_total = 0, cmp_count = 0, cyc = 0;
  assign bus = oe ? h_io : f_io;
  nhc_host uut (.clock_in, .sys_rst_in, .req_valid_in, .req_ready_out, .req_op_in,
    .req_data_in, .req_wait_ready_in, .addr_valid_in, .addr_col_in(12'hA5C),
    .addr_row_in(17'h12345), .write_enable_in, .rd_valid_out, .rd_ready_in, .rd_data_out,
    .busy_out, .page_index_out(page), .block_index_out(blk), .chip_sel_n_out(cs_n),
    .cmd_latch_out(cle), .addr_latch_out(ale), .write_strobe_n_out(we_n),
    .read_strobe_n_out(re_n), .write_guard_n_out(wp_n), .ready_busy_n_in(rb_n),
    .io_in(bus), .io_out(h_io), .io_oe_out(oe));
  nhc_flash_model fm (.chip_sel_n_in(cs_n), .cmd_latch_in(cle), .addr_latch_in(ale),
    .write_strobe_n_in(we_n), .read_strobe_n_in(re_n), .write_guard_n_in(wp_n),
    .io_in(bus), .io_out(f_io), .ready_busy_n_out(rb_n));
  initial forever #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) if (++cyc == 6000) begin
    err_total++;
    final_report();
  end
  task automatic chk(logic [16:0] got, logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    int n = 0;
    do @(negedge clock_in); while (req_ready_out !== 1'b1 && ++n < 400);
    chk(req_ready_out, 17'h00001);
  endtask : wait_rdy
  task automatic req(nhc_op_t op, logic [7:0] d, logic w);
    @(posedge clock_in);
    req_op_in <= op;
    req_data_in <= d;
    req_wait_ready_in <= w;
    req_valid_in <= 1;
    wait_rdy();
    @(posedge clock_in) req_valid_in <= 0;
    @(posedge clock_in);
    @(negedge clock_in);
  endtask : req
  task automatic pop(logic [7:0] exp);
    int n = 0;
    do @(negedge clock_in); while (rd_valid_out !== 1'b1 && ++n < 100);
    chk(rd_valid_out, 17'h00001);
    chk(rd_data_out, exp);
    @(posedge clock_in) rd_ready_in <= 1;
    @(posedge clock_in) rd_ready_in <= 0;
  endtask : pop
  task automatic t_cmd_addr();
    req(NHC_OP_CMD, 8'h30, 0);
    chk(fm.cmd_r, 8'h30);
    @(posedge clock_in) addr_valid_in <= 1;
    wait_rdy();
    @(posedge clock_in) addr_valid_in <= 0;
    wait_rdy();
    chk({fm.addr_q[0], fm.addr_q[1]}, 16'h5C0A);
    chk({fm.addr_q[2], fm.addr_q[3]}, 16'h4523);
    chk(fm.addr_q[4], 8'h01);
    chk({blk, page}, 17'h12345);
    @(posedge clock_in);
    req(NHC_OP_WRITE, 8'h96, 0);
    chk(fm.data_r, 8'h96);
  endtask : t_cmd_addr
  task automatic t_read();
    repeat (5) req(NHC_OP_READ, 8'h00, 0);
    repeat (4) @(negedge clock_in);
    chk(req_ready_out, 0);
    for (int i = 0; i < 5; i++) pop(8'h5C + 8'(i));
  endtask : t_read
  task automatic t_guard();
    write_enable_in <= 0;
    req(NHC_OP_CMD, 8'h10, 1);
    repeat (4) @(negedge clock_in);
    chk(rb_n, 1);
    wait_rdy();
    @(posedge clock_in) write_enable_in <= 1;
    @(posedge clock_in);
    req(NHC_OP_CMD, 8'h10, 1);
    repeat (4) @(negedge clock_in);
    chk({busy_out, req_ready_out, rb_n}, 3'b100);
    wait_rdy();
    chk({busy_out, rb_n}, 2'b01);
  endtask : t_guard
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(posedge clock_in);
    chk({cs_n, we_n, re_n, oe}, 4'hE);
    sys_rst_in <= 0;
    @(posedge clock_in);
    t_cmd_addr();
    t_read();
    t_guard();
    final_report();
  end
endmodule : tb_top
